/* File: scf_params.svh */
// Constants of the stream channel
`ifndef SCF_PARAMS_SVH
`define SCF_PARAMS_SVH
// How it works
// [R1] One producer and one consumer per channel
// [R2] Boundary channel: FIFO port, optional handshake port
// [R3] Local channel is always an internal FIFO
// [R4] One-sided global channel becomes a boundary port
// [R5] Two-sided global channel is an internal FIFO
// [R6] Word width equals total element width
// [R7] Blocking pop stalls empty, push stalls full
// [R8] Handshake transfer stalls until both sides meet
// [R9] Pops return oldest word, each once
// [R10] Try push: success enqueues, failure changes nothing
// [R11] Try pop: success dequeues, failure changes nothing
// [R12] Full set exactly when no free entry
// [R13] Empty set whenever nothing stored
// [R14] Handshake port users issue blocking transfers only
// [R15] Try accesses only on plain FIFO ports
// [R16] Depth defaults to one, configurable larger
// [R17] Reset empties FIFO, empty high, full low
`define SCF_WIDTH_DEF 32
`define SCF_DEPTH_DEF 1
`define SCF_STAGE_DEPTH 32
`define SCF_CNT_W 16
`define SCF_FULL_RST 1'b0
`define SCF_EMPTY_RST 1'b1
`define SCF_PULSE_RST 1'b0
`endif

/* File: scf_pkg.sv */
// Types of the stream channel
`default_nettype none
package scf_pkg;
  typedef enum logic [1:0] {
    SCF_PROTO_FIFO = 2'h1,
    SCF_PROTO_HS = 2'h2
  } scf_proto_type;
  typedef enum logic [2:0] {
    SCF_PLACE_LOCAL = 3'h1,
    SCF_PLACE_SHARED = 3'h2,
    SCF_PLACE_PORT = 3'h4
  } scf_place_type;
  typedef enum logic [2:0] {
    SCF_ST_IDLE = 3'h1,
    SCF_ST_REQ = 3'h2,
    SCF_ST_GAP = 3'h4
  } scf_host_state_type;
endpackage : scf_pkg
`default_nettype wire

/* File: scf_if.sv */
// Carrier between producer end and channel end
`include "scf_params.svh"
`default_nettype none
interface scf_if #(
  parameter int WIDTH = `SCF_WIDTH_DEF
);
  logic push_req;
  logic push_try;
  logic [WIDTH-1:0] push_data;
  logic push_done;
  logic push_ok;
  logic full;
  logic empty;
  modport dev (
    input push_req, push_try, push_data,
    output push_done, push_ok, full, empty
  );
  modport prod (
    output push_req, push_try, push_data,
    input push_done, push_ok, full, empty
  );
endinterface : scf_if
`default_nettype wire

/* File: scf_fifo.sv */
// Parameterised FIFO with registered flags
`include "scf_params.svh"
`default_nettype none
module scf_fifo
  import scf_pkg::*;
#(
  parameter int WIDTH = `SCF_WIDTH_DEF,
  parameter int DEPTH = `SCF_DEPTH_DEF,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready_r,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid_r,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full_r,
  output logic empty_r,
  output logic [CW-1:0] count_r
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CAP = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_nxt;
  logic do_wr;
  logic do_rd;

  assign do_wr = in_valid && in_ready_r; // R10
  assign do_rd = out_ready && out_valid_r; // R11
  assign count_nxt = count_r + CW'(do_wr) - CW'(do_rd);
  assign out_data = mem_r[rd_ptr_r]; // R9

  // Storage, one write port per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_sys) begin
      if (do_wr && wr_ptr_r == AW'(i)) begin
        mem_r[i] <= in_data;
      end
    end
  end

  // Pointers wrap at the last entry
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0; // R17
      rd_ptr_r <= '0; // R17
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1; // R9
      end
    end
  end

  // Occupancy and flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      full_r <= `SCF_FULL_RST; // R17
      empty_r <= `SCF_EMPTY_RST; // R17
      in_ready_r <= 1'b1;
      out_valid_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      full_r <= (count_nxt == CAP); // R12
      empty_r <= (count_nxt == '0); // R13
      in_ready_r <= (count_nxt != CAP);
      out_valid_r <= (count_nxt != '0);
    end
  end
endmodule : scf_fifo
`default_nettype wire

/* File: scf_host.sv */
// Producer end: staging buffer feeding the channel
`include "scf_params.svh"
`default_nettype none
module scf_host
  import scf_pkg::*;
#(
  parameter int WIDTH = `SCF_WIDTH_DEF,
  parameter int STAGE_DEPTH = `SCF_STAGE_DEPTH,
  parameter bit HS_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic try_mode,
  scf_if.prod chan,
  output logic busy_r,
  output logic [`SCF_CNT_W-1:0] sent_cnt_r,
  output logic [`SCF_CNT_W-1:0] retry_cnt_r
);
  scf_host_state_type state_r;
  logic [WIDTH-1:0] data_r;
  logic req_r;
  logic try_r;
  logic stage_valid;
  logic [WIDTH-1:0] stage_data;
  logic stage_pop;
  logic use_try;

  scf_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(src_valid),
    .in_ready_r(src_ready),
    .in_data(src_data),
    .out_valid_r(stage_valid),
    .out_ready(stage_pop),
    .out_data(stage_data),
    .full_r(),
    .empty_r(),
    .count_r()
  );

  // Handshake or stream-resource ports get blocking pushes only
  assign use_try = try_mode && !HS_ONLY; // R14 R15
  // A refused try is retried with the same word after a gap
  assign stage_pop = (state_r == SCF_ST_IDLE) && stage_valid;
  assign chan.push_req = req_r;
  assign chan.push_try = try_r;
  assign chan.push_data = data_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= SCF_ST_IDLE;
      req_r <= 1'b0;
      try_r <= 1'b0;
      data_r <= '0;
      busy_r <= 1'b0;
      sent_cnt_r <= '0;
      retry_cnt_r <= '0;
    end else begin
      unique case (state_r)
        SCF_ST_IDLE: begin
          if (stage_pop) begin
            data_r <= stage_data;
            try_r <= use_try;
            req_r <= 1'b1;
            busy_r <= 1'b1;
            state_r <= SCF_ST_REQ;
          end
        end
        SCF_ST_REQ: begin
          if (chan.push_done) begin
            req_r <= 1'b0;
            if (chan.push_ok) begin
              sent_cnt_r <= sent_cnt_r + 1'b1;
              busy_r <= 1'b0;
              state_r <= SCF_ST_IDLE;
            end else begin
              retry_cnt_r <= retry_cnt_r + 1'b1; // R10
              state_r <= SCF_ST_GAP;
            end
          end
        end
        SCF_ST_GAP: begin
          req_r <= 1'b1;
          state_r <= SCF_ST_REQ;
        end
      endcase
    end
  end
endmodule : scf_host
`default_nettype wire

/* File: scf_dev.sv */
// Channel end: stores or hands over words to one consumer
`include "scf_params.svh"
`default_nettype none
module scf_dev
  import scf_pkg::*;
#(
  parameter int WIDTH = `SCF_WIDTH_DEF,
  parameter int DEPTH = `SCF_DEPTH_DEF,
  parameter scf_proto_type PROTO = SCF_PROTO_FIFO,
  parameter scf_place_type PLACE = SCF_PLACE_LOCAL,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  scf_if.dev chan,
  input wire logic pop_req,
  input wire logic pop_try,
  output logic pop_done_r,
  output logic pop_ok_r,
  output logic [WIDTH-1:0] pop_data_r,
  output logic pop_empty,
  output logic push_full,
  output logic [CW-1:0] level_r,
  output logic hs_mode_r,
  output logic [`SCF_CNT_W-1:0] push_fail_cnt_r,
  output logic [`SCF_CNT_W-1:0] pop_fail_cnt_r
);
  // Only a one-sided global channel may leave as a port;
  // local and two-sided channels always stay a plain FIFO
  localparam scf_proto_type EFF =
    (PLACE == SCF_PLACE_PORT) ? PROTO : SCF_PROTO_FIFO; // R2 R3 R4 R5
  localparam logic USE_HS = (EFF == SCF_PROTO_HS);

  logic push_done_r;
  logic push_ok_r;
  logic f_in_ready;
  logic f_out_valid;
  logic [WIDTH-1:0] f_data;
  logic [CW-1:0] f_count;
  logic push_take;
  logic push_wr;
  logic push_fail;
  logic pop_take;
  logic pop_rd;
  logic pop_fail;
  logic hs_xfer;

  // Storage for the FIFO form of the channel
  scf_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_store (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(push_wr),
    .in_ready_r(f_in_ready),
    .in_data(chan.push_data),
    .out_valid_r(f_out_valid),
    .out_ready(pop_rd),
    .out_data(f_data),
    .full_r(push_full),
    .empty_r(pop_empty),
    .count_r(f_count)
  ); // R6 R16

  assign chan.full = push_full; // R12
  assign chan.empty = pop_empty; // R13
  assign chan.push_done = push_done_r;
  assign chan.push_ok = push_ok_r;

  // Push side: one producer, one request answered at a time.
  // A blocking request waits for space, a try is answered at once.
  assign push_take = !USE_HS && chan.push_req && !push_done_r &&
                     (chan.push_try || f_in_ready); // R1 R7
  assign push_wr = push_take && f_in_ready; // R10
  assign push_fail = push_take && !f_in_ready; // R10

  // Pop side, mirrored
  assign pop_take = !USE_HS && pop_req && !pop_done_r &&
                    (pop_try || f_out_valid); // R1 R7
  assign pop_rd = pop_take && f_out_valid; // R11
  assign pop_fail = pop_take && !f_out_valid; // R11

  // Handshake form: a word moves only when both sides ask;
  // try flags are ignored since such users block
  assign hs_xfer = USE_HS && chan.push_req && pop_req &&
                   !push_done_r && !pop_done_r; // R8 R14

  // Push answer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      push_done_r <= `SCF_PULSE_RST;
      push_ok_r <= `SCF_PULSE_RST;
    end else begin
      push_done_r <= push_take || hs_xfer; // R7 R8
      push_ok_r <= push_wr || hs_xfer; // R10
    end
  end

  // Pop answer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pop_done_r <= `SCF_PULSE_RST;
      pop_ok_r <= `SCF_PULSE_RST;
    end else begin
      pop_done_r <= pop_take || hs_xfer; // R7 R8
      pop_ok_r <= pop_rd || hs_xfer; // R11
    end
  end

  // Delivered word, held until the next successful pop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pop_data_r <= '0;
    end else if (pop_rd) begin
      pop_data_r <= f_data; // R9
    end else if (hs_xfer) begin
      pop_data_r <= chan.push_data; // R8
    end
  end

  // Occupancy and mode as seen by the consumer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_r <= '0; // R17
      hs_mode_r <= 1'b0;
    end else begin
      level_r <= f_count;
      hs_mode_r <= USE_HS;
    end
  end

  // Refused try counts, saturating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      push_fail_cnt_r <= '0;
      pop_fail_cnt_r <= '0;
    end else begin
      if (push_fail && push_fail_cnt_r != '1) begin
        push_fail_cnt_r <= push_fail_cnt_r + 1'b1;
      end
      if (pop_fail && pop_fail_cnt_r != '1) begin
        pop_fail_cnt_r <= pop_fail_cnt_r + 1'b1;
      end
    end
  end
endmodule : scf_dev
`default_nettype wire

/* File: scf_chan_assertions.sv */
// Checker of the channel interface between the two ends
`include "scf_params.svh"
`default_nettype none
module scf_chan_assertions #(
  parameter int WIDTH = `SCF_WIDTH_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic push_req,
  input wire logic push_try,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic push_done,
  input wire logic push_ok,
  input wire logic full,
  input wire logic empty
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic ask = push_req && !push_done;
  property p_take; ask && !full |=> push_done && push_ok; endproperty
  a_take: assert property (p_take) else $error("free push not taken");
  property p_refuse; ask && push_try && full |=> push_done && !push_ok;
  endproperty
  a_refuse: assert property (p_refuse) else $error("full try taken");
  property p_stall; ask && !push_try && full |=> !push_done; endproperty
  a_stall: assert property (p_stall) else $error("full push answered");
  property p_pulse; push_done |=> !push_done; endproperty
  a_pulse: assert property (p_pulse) else $error("answer repeated");
  property p_cause; push_done |-> $past(push_req); endproperty
  a_cause: assert property (p_cause) else $error("answer unasked");
  property p_flags; !(full && empty); endproperty
  a_flags: assert property (p_flags) else $error("full and empty");
  property p_fill; $fell(empty) |-> push_done && push_ok; endproperty
  a_fill: assert property (p_fill) else $error("empty fell alone");
  property p_full; $rose(full) |-> push_done && push_ok; endproperty
  a_full: assert property (p_full) else $error("full rose alone");
  property p_rst; $rose(rstn) |-> empty && !full && !push_done; endproperty
  a_rst: assert property (p_rst) else $error("bad flags after reset");
  property p_held; ask |=> push_done || $stable(push_data); endproperty
  a_held: assert property (p_held) else $error("word moved");
endmodule : scf_chan_assertions
`default_nettype wire

/* File: stream_channel_fifo_test.sv */
// Testbench of the stream channel, both ends joined
`include "scf_params.svh"
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module stream_channel_fifo_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scf_pkg::*;
  localparam int W = 16;
  localparam int D = 4;
  logic clk_sys = 0, rstn = 0, src_valid = 0, try_mode = 0;
  logic pop_req = 0, pop_try = 0;
  logic src_ready, busy_r, pop_done_r, pop_ok_r, pop_empty, push_full, hs_r;
  logic [W-1:0] src_data = '0, pop_data_r;
  logic [2:0] level_r;
  logic [`SCF_CNT_W-1:0] sent_cnt_r, retry_cnt_r, pfail_r, ofail_r;
  logic h_valid = 0, h_pop = 0, h_ready, h_busy, h_done, h_ok, h_empty;
  logic h_full, h_hs, h_level;
  logic [W-1:0] h_data;
  logic [`SCF_CNT_W-1:0] h_sent, h_retry, h_pfail, h_ofail;
  int mismatches = 0, checks = 0, total = 0;
  always #12.5 clk_sys = ~clk_sys;
  scf_if #(.WIDTH(W)) i_scf_if ();
  scf_if #(.WIDTH(W)) i_scf_if_hs ();
  scf_host #(.WIDTH(W)) i_scf_host (.clk_sys(clk_sys), .rstn(rstn),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .try_mode(try_mode), .chan(i_scf_if), .busy_r(busy_r),
    .sent_cnt_r(sent_cnt_r), .retry_cnt_r(retry_cnt_r));
  scf_dev #(.WIDTH(W), .DEPTH(D)) i_scf_dev (.clk_sys(clk_sys), .rstn(rstn),
    .chan(i_scf_if), .pop_req(pop_req), .pop_try(pop_try),
    .pop_done_r(pop_done_r), .pop_ok_r(pop_ok_r), .pop_data_r(pop_data_r),
    .pop_empty(pop_empty), .push_full(push_full), .level_r(level_r),
    .hs_mode_r(hs_r), .push_fail_cnt_r(pfail_r), .pop_fail_cnt_r(ofail_r));
  // Handshake pair: boundary port, producer forced to block
  scf_host #(.WIDTH(W), .HS_ONLY(1'b1)) i_scf_host_hs (.clk_sys(clk_sys),
    .rstn(rstn), .src_valid(h_valid), .src_ready(h_ready),
    .src_data(src_data), .try_mode(try_mode), .chan(i_scf_if_hs),
    .busy_r(h_busy), .sent_cnt_r(h_sent), .retry_cnt_r(h_retry));
  scf_dev #(.WIDTH(W), .PROTO(SCF_PROTO_HS), .PLACE(SCF_PLACE_PORT))
    i_scf_dev_hs (.clk_sys(clk_sys), .rstn(rstn), .chan(i_scf_if_hs),
    .pop_req(h_pop), .pop_try(pop_try), .pop_done_r(h_done),
    .pop_ok_r(h_ok), .pop_data_r(h_data), .pop_empty(h_empty),
    .push_full(h_full), .level_r(h_level), .hs_mode_r(h_hs),
    .push_fail_cnt_r(h_pfail), .pop_fail_cnt_r(h_ofail));
  scf_chan_assertions #(.WIDTH(W)) i_scf_chan_assertions (.clk_sys(clk_sys),
    .rstn(rstn), .push_req(i_scf_if.push_req),
    .push_try(i_scf_if.push_try), .push_data(i_scf_if.push_data),
    .push_done(i_scf_if.push_done), .push_ok(i_scf_if.push_ok),
    .full(i_scf_if.full), .empty(i_scf_if.empty));
  task automatic close_out;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic pop(input logic t, input logic ok, input logic [W-1:0] d);
    int n;
    @(negedge clk_sys);
    pop_req = 1;
    pop_try = t;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pop_done_r !== 1'b1 && n < 200);
    pop_req = 0;
    `CHK(pop_ok_r, ok)
    if (ok) `CHK(pop_data_r, d)
  endtask : pop
  task automatic send(input logic [W-1:0] d);
    @(negedge clk_sys);
    src_valid = 1;
    src_data = d;
    while (!src_ready) @(negedge clk_sys);
    total++;
  endtask : send
  task automatic idle;
    @(negedge clk_sys);
    src_valid = 0;
    repeat (8) @(negedge clk_sys);
  endtask : idle
  task automatic t_reset;
    `CHK(pop_empty, 1'b1)
    `CHK(push_full, 1'b0)
    `CHK(level_r, 3'h0)
    `CHK(pop_data_r, 16'h0)
  endtask : t_reset
  task automatic t_order;
    pop(1'b1, 1'b0, 16'h0);
    fork
      pop(1'b0, 1'b1, 16'hA5A5);
      begin
        repeat (4) @(negedge clk_sys);
        send(16'hA5A5);
        send(16'h5A5A);
        send(16'h0001);
        idle;
      end
    join
    `CHK(ofail_r, 16'h1)
    `CHK(hs_r, 1'b0)
    pop(1'b1, 1'b1, 16'h5A5A);
    pop(1'b0, 1'b1, 16'h0001);
    `CHK(pop_empty, 1'b1)
  endtask : t_order
  task automatic t_full;
    try_mode = 1;
    for (int i = 0; i < D + 2; i++) send(16'(16'h100 + i));
    idle;
    `CHK(push_full, 1'b1)
    `CHK(level_r, 3'(D))
    for (int i = 0; i < D + 2; i++) pop(1'b0, 1'b1, 16'(16'h100 + i));
    `CHK(push_full, 1'b0)
    `CHK(retry_cnt_r != 16'h0, 1'b1)
    `CHK(pfail_r, retry_cnt_r)
    try_mode = 0;
  endtask : t_full
  task automatic t_stage;
    int n;
    n = 0;
    @(negedge clk_sys);
    while (src_ready && n < 60) begin
      src_valid = 1;
      src_data = 16'(n);
      n++;
      total++;
      @(negedge clk_sys);
    end
    src_valid = 0;
    `CHK(n > 32, 1'b1)
    `CHK(busy_r, 1'b1)
    for (int i = 0; i < n; i++) pop(1'b0, 1'b1, 16'(i));
    `CHK(pop_empty, 1'b1)
    `CHK(busy_r, 1'b0)
  endtask : t_stage
  task automatic t_hs;
    int n;
    @(negedge clk_sys);
    try_mode = 1;
    pop_try = 1;
    h_valid = 1;
    src_data = 16'hC3C3;
    @(negedge clk_sys);
    h_valid = 0;
    repeat (6) @(negedge clk_sys);
    `CHK(h_busy, 1'b1)
    `CHK(i_scf_if_hs.push_try, 1'b0)
    `CHK(h_done, 1'b0)
    h_pop = 1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (h_done !== 1'b1 && n < 20);
    h_pop = 0;
    `CHK(h_ok, 1'b1)
    `CHK(h_data, 16'hC3C3)
    `CHK(h_hs, 1'b1)
    `CHK({h_full, h_empty, h_level}, 3'b010)
    @(negedge clk_sys);
    `CHK(h_busy, 1'b0)
    `CHK(h_sent, 16'h1)
    `CHK({h_retry, h_pfail, h_ofail}, 48'h0)
    try_mode = 0;
  endtask : t_hs
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rstn = 1;
    t_reset;
    t_order;
    t_full;
    t_stage;
    t_hs;
    repeat (4) @(negedge clk_sys);
    `CHK(sent_cnt_r, 16'(total))
    send(16'h77);
    idle;
    rstn = 0;
    repeat (2) @(negedge clk_sys);
    rstn = 1;
    t_reset;
    pop(1'b1, 1'b0, 16'h0);
    close_out;
  end
endmodule : stream_channel_fifo_test
`default_nettype wire
